// ===== shared/umaf_cfg.svh
// Register offsets, field positions, reset values and sampling constants
`ifndef UMAF_CFG_SVH
`define UMAF_CFG_SVH
`define UMAF_OFF_CSA   12'h000
`define UMAF_OFF_CSB   12'h004
`define UMAF_OFF_CSC   12'h008
`define UMAF_OFF_DATA  12'h00c
`define UMAF_OFF_BAUD  12'h010
`define UMAF_A_RXC     7
`define UMAF_A_TXC     6
`define UMAF_A_DRE     5
`define UMAF_A_FE      4
`define UMAF_A_DOR     3
`define UMAF_A_PE      2
`define UMAF_A_DSP     1
`define UMAF_A_AFM     0
`define UMAF_B_RXEN    4
`define UMAF_B_TXEN    3
`define UMAF_B_CSZ2    2
`define UMAF_B_RX9     1
`define UMAF_B_TX9     0
`define UMAF_C_PEN     5
`define UMAF_C_PODD    4
`define UMAF_C_STOP2   3
`define UMAF_C_CSZ1    2
`define UMAF_C_CSZ0    1
`define UMAF_CSZ_RST   3'h3
`define UMAF_CSZ_NINE  3'h7
`define UMAF_SPB_NORM  5'h10
`define UMAF_SPB_DBL   5'h08
`define UMAF_SF_NORM   5'h08
`define UMAF_SF_DBL    5'h04
`endif

// ===== shared/umaf_pkg.sv
// Types shared by the serial receiver, transmitter and register file
package umaf_pkg;
   // Receive sequencer, one-hot
   typedef enum logic [3:0] {
      umaf_idle  = 4'b0001,
      umaf_start = 4'b0010,
      umaf_data  = 4'b0100,
      umaf_stop  = 4'b1000
   } umaf_rx_e;
   // One receive buffer entry
   typedef struct packed {
      logic [8:0] data;
      logic       fe;
      logic       pe;
   } umaf_rxw_s;
   // Frame format seen by both directions
   typedef struct packed {
      logic [2:0] csz;
      logic       pen;
      logic       podd;
      logic       two_stop;
   } umaf_fmt_s;
endpackage

// ===== hdl/umaf_baud.sv
// Baud divider giving one sample tick per divisor+1 clocks
`timescale 1ns/100ps
`default_nettype none
module umaf_baud #(
   parameter int DIV_W = 12
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             arst_n,
   // Divisor and tick
   input  wire logic [DIV_W-1:0] div,
   output logic                  tick
);
   logic [DIV_W-1:0] cnt;   // Down counter

   // Reload on zero; the tick is a one-cycle enable
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt  <= '0;
         tick <= 1'b0;
      end
      else
      begin
         tick <= (cnt == '0);
         cnt  <= (cnt == '0) ? div : cnt - 1'b1;
      end
   end
endmodule
`default_nettype wire

// ===== hdl/umaf_tx.sv
// Transmitter: start, data, optional parity and one or two stop bits
`timescale 1ns/100ps
`default_nettype none
`include "umaf_cfg.svh"
module umaf_tx (
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                arst_n,
   // Timing and format
   input  wire logic                tick,
   input  wire logic                dsp,
   input  wire umaf_pkg::umaf_fmt_s fmt,
   // Character in
   input  wire logic                load,
   input  wire logic [8:0]          data,
   // Line and status
   output logic                     txd,
   output logic                     idle,
   output logic                     done
);
   logic [11:0] sh;     // Bits still to send, LSB first
   logic [3:0]  left;   // Bits remaining
   logic [4:0]  cnt;    // Sample ticks in current bit
   logic [11:0] img;    // Frame image built at load
   logic [3:0]  nd;     // Data bits
   logic        par;    // Parity over the data bits only

   // Build frame; no filter input exists, so sending never depends on it
   // Reserved size codes send eight bits, as the receiver expects
   always_comb
   begin
      par = fmt.podd;
      nd = (fmt.csz == `UMAF_CSZ_NINE) ? 4'd9 : (fmt.csz[2] ? 4'd8 : {2'b01, fmt.csz[1:0]} + 4'd1);
      img = '1;
      img[0] = 1'b0;
      for (int i = 0; i < 9; i++)
         if (i < nd)
         begin
            img[i+1] = data[i];
            par      = par ^ data[i];
         end
      if (fmt.pen)
         img[nd+1] = par;
   end

   // Shift one bit per 16 or 8 ticks
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sh <= '1; left <= '0; cnt <= '0; txd <= 1'b1; idle <= 1'b1; done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (load && idle)
         begin
            sh   <= img;
            left <= nd + 4'd2 + {3'b0, fmt.pen} + {3'b0, fmt.two_stop};
            cnt  <= '0;
            idle <= 1'b0;
         end
         else if (!idle && tick)
         begin
            // Bit boundary: drive next bit or finish
            if (cnt == 5'd0)
            begin
               if (left == 4'd0)
               begin
                  idle <= 1'b1;
                  done <= 1'b1;
                  txd  <= 1'b1;
               end
               else
               begin
                  txd  <= sh[0];
                  sh   <= {1'b1, sh[11:1]};
                  left <= left - 4'd1;
               end
            end
            cnt <= (cnt == (dsp ? `UMAF_SPB_DBL : `UMAF_SPB_NORM) - 5'd1) ? 5'd0 : cnt + 5'd1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== hdl/umaf_top.sv
// Serial port with address-filtering receiver, transmitter and APB registers
// Operation
// - Filter on: drop non-address frames unbuffered
// - Five to eight bits: stop bit marks type
// - Nine bits: ninth data bit marks type
// - Marker one means address, zero data
// - Transmitter ignores the filter mode
// - Kept address frame stored, completes normally
// - Filter off accepts data frames; on ignores
// - One character size for both directions
// - Sixteen or eight samples per bit
// - First voted sample eight or four
// - Middle voted sample nine or five
// - Five to ten data-plus-parity bits
// - Normal eight-bit tolerance 95.36 to 104.58 percent
// - Split rate error equally between ends
// - Start bit majority-voted; high means noise
// - Double speed halves samples per bit
`timescale 1ns/100ps
`default_nettype none
`include "umaf_cfg.svh"
module umaf_top #(
   parameter int DIV_W = 12
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial pins
   input  wire logic        serial_rx_pin,
   output logic             serial_tx_pin
);
   // Control registers
   logic             addr_filter_mode;    // Receive address filter
   logic             double_speed_sel;    // 8 samples per bit
   logic             tx_complete_flag;    // Sticky, write one to clear
   logic             rx_en;               // Receiver enable
   logic             tx_en;               // Transmitter enable
   logic [2:0]       char_size_sel;       // Shared by both directions
   logic             two_stop_sel;        // Transmit two stop bits
   logic [1:0]       pmode;               // Parity enable, odd
   logic             tx_ninth_bit;        // Ninth bit to send
   logic [DIV_W-1:0] baud_divisor;        // Tick every divisor+1 clocks
   // Transmit buffer
   logic [8:0]       txbuf;               // One pending character
   logic             txbuf_v;             // Pending character valid
   logic             tx_idle;             // Shifter idle
   logic             tx_done;             // Shifter finished frame
   // Receive buffer, two entries
   umaf_pkg::umaf_rxw_s rxq [2];          // Stored frames
   logic             rd_ptr;              // Head index
   logic [1:0]       fill;                // Entries held
   logic             dor;                 // Overrun seen
   // Receive sequencer
   umaf_pkg::umaf_rx_e state;             // Current phase
   logic [4:0]       cnt;                 // Sample number in bit
   logic [1:0]       smp;                 // Samples SF and SF+1
   logic [3:0]       idx;                 // Bit number in frame
   logic [9:0]       sr;                  // Data and parity bits
   logic             tick;                // Sample tick
   umaf_pkg::umaf_fmt_s fmt;              // Common frame format

   // Majority of three samples
   function automatic logic vote3(input logic a, input logic b, input logic c);
      return (a & b) | (a & c) | (b & c);
   endfunction

   // Data bits for a size code; reserved codes act as eight
   function automatic logic [3:0] data_bits(input logic [2:0] c);
      if (c == `UMAF_CSZ_NINE)
         return 4'd9;
      return c[2] ? 4'd8 : {2'b01, c[1:0]} + 4'd1;
   endfunction

   // Keep the low n bits, clear the rest
   function automatic logic [8:0] low_bits(input logic [9:0] s, input logic [3:0] n);
      logic [8:0] d;
      d = '0;
      for (int i = 0; i < 9; i++)
         if (i < n)
            d[i] = s[i];
      return d;
   endfunction

   assign fmt = '{csz: char_size_sel, pen: pmode[1], podd: pmode[0], two_stop: two_stop_sel};

   // Sampling geometry per speed
   logic [4:0] spb;
   logic [4:0] sf;
   assign spb = double_speed_sel ? `UMAF_SPB_DBL : `UMAF_SPB_NORM;
   assign sf  = double_speed_sel ? `UMAF_SF_DBL : `UMAF_SF_NORM;

   // Frame length and end-of-frame decode
   logic [3:0] nd;
   logic [3:0] total;
   logic       maj;
   logic       vote_now;
   logic       frame_end;
   logic       marker;
   logic       keep;
   logic       store;
   logic       overrun;
   logic [8:0] rx_word;
   logic       rx_pe;
   assign nd        = data_bits(char_size_sel);
   assign total     = nd + {3'b0, pmode[1]};
   assign maj       = vote3(smp[1], smp[0], serial_rx_pin);
   assign vote_now  = tick && state != umaf_pkg::umaf_idle && cnt == sf + 5'd1;
   assign frame_end = vote_now && state == umaf_pkg::umaf_stop;
   assign rx_word   = low_bits(sr, nd);
   assign rx_pe     = pmode[1] & (^rx_word ^ sr[nd] ^ pmode[0]);
   assign marker    = (char_size_sel == `UMAF_CSZ_NINE) ? sr[8] : maj;
   assign keep      = !addr_filter_mode || marker;
   assign store     = frame_end && keep && fill != 2'd2;
   assign overrun   = frame_end && keep && fill == 2'd2;

   // APB decode
   logic setup;
   logic wr;
   logic rd;
   logic hit;
   logic pop;
   assign setup = psel && !penable;
   assign wr    = psel && penable && pready && pwrite;
   assign rd    = psel && penable && pready && !pwrite;
   assign hit   = paddr == `UMAF_OFF_CSA || paddr == `UMAF_OFF_CSB || paddr == `UMAF_OFF_CSC
                  || paddr == `UMAF_OFF_DATA || paddr == `UMAF_OFF_BAUD;
   assign pop   = rd && paddr == `UMAF_OFF_DATA && fill != 2'd0;

   // Read view of the registers
   logic [31:0] rmux;
   always_comb
   begin
      rmux = '0;
      unique case (paddr)
         `UMAF_OFF_CSA:
         begin
            rmux[`UMAF_A_RXC] = fill != 2'd0;
            rmux[`UMAF_A_TXC] = tx_complete_flag;
            rmux[`UMAF_A_DRE] = !txbuf_v;
            rmux[`UMAF_A_FE]  = fill != 2'd0 && rxq[rd_ptr].fe;
            rmux[`UMAF_A_DOR] = dor;
            rmux[`UMAF_A_PE]  = fill != 2'd0 && rxq[rd_ptr].pe;
            rmux[`UMAF_A_DSP] = double_speed_sel;
            rmux[`UMAF_A_AFM] = addr_filter_mode;
         end
         `UMAF_OFF_CSB:
         begin
            rmux[`UMAF_B_RXEN] = rx_en;
            rmux[`UMAF_B_TXEN] = tx_en;
            rmux[`UMAF_B_CSZ2] = char_size_sel[2];
            rmux[`UMAF_B_RX9]  = rxq[rd_ptr].data[8];
            rmux[`UMAF_B_TX9]  = tx_ninth_bit;
         end
         `UMAF_OFF_CSC:
         begin
            rmux[`UMAF_C_PEN]   = pmode[1];
            rmux[`UMAF_C_PODD]  = pmode[0];
            rmux[`UMAF_C_STOP2] = two_stop_sel;
            rmux[`UMAF_C_CSZ1]  = char_size_sel[1];
            rmux[`UMAF_C_CSZ0]  = char_size_sel[0];
         end
         `UMAF_OFF_DATA:
            rmux[7:0] = rxq[rd_ptr].data[7:0];
         `UMAF_OFF_BAUD:
            rmux[DIV_W-1:0] = baud_divisor;
         default:
            rmux = '0;
      endcase
   end

   // Answer one cycle after setup; read data captured at setup
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pready <= 1'b0; pslverr <= 1'b0; prdata <= '0;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup && !hit;
         prdata  <= (setup && !pwrite) ? rmux : '0;
      end
   end

   // Control register writes; filter bit sits beside the write-one-clear flag
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         addr_filter_mode <= 1'b0; double_speed_sel <= 1'b0; rx_en <= 1'b0; tx_en <= 1'b0;
         char_size_sel <= `UMAF_CSZ_RST; two_stop_sel <= 1'b0; pmode <= '0;
         tx_ninth_bit <= 1'b0; baud_divisor <= '0;
      end
      else if (wr)
      begin
         unique case (paddr)
            `UMAF_OFF_CSA:
            begin
               addr_filter_mode <= pwdata[`UMAF_A_AFM];
               double_speed_sel <= pwdata[`UMAF_A_DSP];
            end
            `UMAF_OFF_CSB:
            begin
               rx_en            <= pwdata[`UMAF_B_RXEN];
               tx_en            <= pwdata[`UMAF_B_TXEN];
               char_size_sel[2] <= pwdata[`UMAF_B_CSZ2];
               tx_ninth_bit     <= pwdata[`UMAF_B_TX9];
            end
            `UMAF_OFF_CSC:
            begin
               pmode              <= pwdata[`UMAF_C_PEN:`UMAF_C_PODD];
               two_stop_sel       <= pwdata[`UMAF_C_STOP2];
               char_size_sel[1:0] <= pwdata[`UMAF_C_CSZ1:`UMAF_C_CSZ0];
            end
            `UMAF_OFF_BAUD:
               baud_divisor <= pwdata[DIV_W-1:0];
            default:
               ;
         endcase
      end
   end

   // Transmit buffer and complete flag; completion wins over a clear
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         txbuf <= '0; txbuf_v <= 1'b0; tx_complete_flag <= 1'b0;
      end
      else
      begin
         if (wr && paddr == `UMAF_OFF_DATA && !txbuf_v)
         begin
            txbuf   <= {tx_ninth_bit, pwdata[7:0]};
            txbuf_v <= 1'b1;
         end
         else if (txbuf_v && tx_idle && tx_en)
            txbuf_v <= 1'b0;
         if (tx_done && !txbuf_v)
            tx_complete_flag <= 1'b1;
         else if (wr && paddr == `UMAF_OFF_CSA && pwdata[`UMAF_A_TXC])
            tx_complete_flag <= 1'b0;
      end
   end

   // Receive sequencer; line taken as synchronous
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state <= umaf_pkg::umaf_idle; cnt <= '0; smp <= '0; idx <= '0; sr <= '0;
      end
      else if (!rx_en)
         state <= umaf_pkg::umaf_idle;          // Disabling drops a frame at once
      else if (tick)
      begin
         if (state == umaf_pkg::umaf_idle)
         begin
            // Falling edge: this is sample 1
            if (!serial_rx_pin)
            begin
               state <= umaf_pkg::umaf_start;
               cnt   <= 5'd1;
            end
         end
         else
         begin
            cnt <= (cnt == spb) ? 5'd1 : cnt + 5'd1;
            // cnt names the sample last taken, so this tick takes cnt+1
            if (cnt == sf - 5'd1 || cnt == sf)
               smp <= {smp[0], serial_rx_pin};
            if (cnt == sf + 5'd1)
            begin
               // Stop ends at the vote so an early start is caught
               if (state == umaf_pkg::umaf_start && maj)
                  state <= umaf_pkg::umaf_idle;
               else if (state == umaf_pkg::umaf_stop)
                  state <= umaf_pkg::umaf_idle;
               else if (state == umaf_pkg::umaf_data)
                  sr[idx] <= maj;
            end
            if (cnt == spb && state == umaf_pkg::umaf_start)
            begin
               state <= umaf_pkg::umaf_data;
               idx   <= '0;
            end
            else if (cnt == spb && state == umaf_pkg::umaf_data)
            begin
               idx <= idx + 4'd1;
               if (idx == total - 4'd1)
                  state <= umaf_pkg::umaf_stop;
            end
         end
      end
   end

   // Receive buffer; dropped frames never reach it
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rxq[0] <= '0; rxq[1] <= '0; rd_ptr <= 1'b0; fill <= '0; dor <= 1'b0;
      end
      else if (!rx_en)
      begin
         fill <= '0; dor <= 1'b0;
      end
      else
      begin
         if (store)
            rxq[rd_ptr ^ fill[0]] <= '{data: rx_word, fe: !maj, pe: rx_pe};
         if (pop)
            rd_ptr <= !rd_ptr;
         fill <= fill + {1'b0, store} - {1'b0, pop};
         if (overrun)
            dor <= 1'b1;
         else if (store)
            dor <= 1'b0;
      end
   end

   // Sample tick source
   umaf_baud #(.DIV_W(DIV_W)) u_baud (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .div     (baud_divisor),
      .tick    (tick)
   );

   // Transmitter; no filter input by design
   umaf_tx u_tx (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .tick    (tick),
      .dsp     (double_speed_sel),
      .fmt     (fmt),
      .load    (txbuf_v && tx_en),
      .data    (txbuf),
      .txd     (serial_tx_pin),
      .idle    (tx_idle),
      .done    (tx_done)
   );

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   a_filter_drop: assert property (frame_end && addr_filter_mode && !marker |=> $stable(fill) || $past(pop))
      else $error("filtered frame entered buffer");
   a_stop_marker: assert property (frame_end && char_size_sel != `UMAF_CSZ_NINE && maj && fill == 2'd0
      |=> fill == 2'd1)
      else $error("stop bit not used as marker");
   a_ninth_marker: assert property (frame_end && char_size_sel == `UMAF_CSZ_NINE && addr_filter_mode
      && !sr[8] && fill == 2'd0 |=> fill == 2'd0)
      else $error("ninth bit not used as marker");
   a_addr_stored: assert property (frame_end && marker && fill == 2'd0 && !pop |=> fill == 2'd1)
      else $error("address frame not stored");
   a_data_accept: assert property (frame_end && !addr_filter_mode && fill == 2'd0 |=> fill == 2'd1)
      else $error("data frame dropped with filter off");
   a_sample_range: assert property (state != umaf_pkg::umaf_idle |-> cnt >= 5'd1 && cnt <= spb)
      else $error("sample number outside bit");
   a_start_noise: assert property (tick && state == umaf_pkg::umaf_start && cnt == sf + 5'd1 && maj && rx_en
      |=> state == umaf_pkg::umaf_idle)
      else $error("noisy start bit accepted");
   a_no_flags: assert property (frame_end && !keep |=> $stable(dor) && $stable(rxq[0]) && $stable(rxq[1]))
      else $error("dropped frame changed status");
   a_vote_point: assert property (tick && state != umaf_pkg::umaf_idle && cnt == sf - 5'd1 && rx_en
      |=> smp[0] == $past(serial_rx_pin))
      else $error("vote taken at wrong sample");

   c_addr_kept:  cover property (frame_end && addr_filter_mode && marker);
   c_data_drop:  cover property (frame_end && addr_filter_mode && !marker);
   c_overrun:    cover property (overrun);
   c_noise:      cover property (state == umaf_pkg::umaf_start ##1 state == umaf_pkg::umaf_idle);
endmodule
`default_nettype wire

// ===== dv/umaf_far_end.sv
// Far-end serial node: sends frames to the receiver and decodes transmitted frames
`timescale 1ns/100ps
`default_nettype none
module umaf_far_end (
   // Clock
   input  wire logic ref_clk,
   // Serial lines
   output var  logic rx_line,
   input  wire logic tx_line
);
   // Idle line is high, like the pull-up level of a released bus
   initial rx_line = 1'b1;

   // One bit time of cpb clocks, changed just after an edge
   task automatic bit_out(input logic v, input int cpb);
      begin
         rx_line <= v;
         repeat (cpb) @(posedge ref_clk);
      end
   endtask

   // Start bit, data LSB first, type marker as first stop, then a second stop
   task automatic send(input logic [8:0] d, input int nb, input logic mark, input int cpb);
      int i;
      begin
         @(posedge ref_clk);
         bit_out(1'b0, cpb);
         for (i = 0; i < nb; i++)
         begin
            bit_out(d[i], cpb);
         end
         bit_out(mark, cpb);
         bit_out(1'b1, cpb);
      end
   endtask

   // Short low spike that must be voted away as noise
   task automatic glitch(input int n);
      begin
         @(posedge ref_clk);
         bit_out(1'b0, n);
         bit_out(1'b1, 40);
      end
   endtask

   // Decode eight bits at mid-bit after the start edge; bounded wait
   task automatic recv(output logic [7:0] d, input int cpb);
      int i;
      int n;
      begin
         n = 0;
         d = 8'h00;
         while (tx_line !== 1'b0 && n < 5000)
         begin
            @(posedge ref_clk);
            n++;
         end
         repeat (cpb / 2) @(posedge ref_clk);
         for (i = 0; i < 8; i++)
         begin
            repeat (cpb) @(posedge ref_clk);
            d[i] = tx_line;
         end
      end
   endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the address-filtering serial port
`timescale 1ns/100ps
`default_nettype none
`include "umaf_cfg.svh"
module tb;
   logic        ref_clk = 1'b0;  // 40 MHz clock
   logic        arst_n  = 1'b0;  // Held low for six cycles
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        rx_line;
   logic        tx_line;
   logic [7:0]  got;
   int          errors = 0;
   int          comparisons = 0;

   // Clock
   always #12.5 ref_clk = ~ref_clk;

   umaf_top #(.DIV_W(12)) DUT (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_rx_pin(rx_line), .serial_tx_pin(tx_line));
   umaf_far_end far (.ref_clk(ref_clk), .rx_line(rx_line), .tx_line(tx_line));

   // Compare and count
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      begin
         comparisons++;
         if (g !== x)
         begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
         end
      end
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      begin
         @(posedge ref_clk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge ref_clk);
         penable <= 1'b1;
         n = 0;
         do
         begin
            @(posedge ref_clk);
            n++;
         end
         while (pready !== 1'b1);
         q = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         chk("pready wait", 32'h1, n);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask

   // Masked read against an expected value
   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(nm, x, q & m);
   endtask

   // Reset values and an unmapped address
   task automatic t_reset;
      logic [31:0] q;
      logic        e;
      rd("csa", `UMAF_OFF_CSA, 32'hffffffff, 32'h00000020);
      rd("csb", `UMAF_OFF_CSB, 32'hffffffff, 32'h00000000);
      rd("csc", `UMAF_OFF_CSC, 32'hffffffff, 32'h00000006);
      rd("baud", `UMAF_OFF_BAUD, 32'hffffffff, 32'h00000000);
      apb(1'b0, 12'h014, 32'h0, q, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, q);
   endtask

   // Nine-bit characters: ninth bit is the frame type
   task automatic t_nine;
      wr(`UMAF_OFF_CSB, 32'h1c);
      wr(`UMAF_OFF_CSA, 32'h01);
      far.send(9'h055, 9, 1'b1, 16);
      rd("data frame dropped", `UMAF_OFF_CSA, 32'h9c, 32'h00);
      far.send(9'h1a3, 9, 1'b1, 16);
      rd("address kept", `UMAF_OFF_CSA, 32'h9c, 32'h80);
      rd("ninth bit", `UMAF_OFF_CSB, 32'h02, 32'h02);
      rd("address data", `UMAF_OFF_DATA, 32'hff, 32'ha3);
      wr(`UMAF_OFF_CSA, 32'h00);
      far.send(9'h03c, 9, 1'b1, 16);
      rd("ninth bit low", `UMAF_OFF_CSB, 32'h02, 32'h00);
      rd("data accepted", `UMAF_OFF_DATA, 32'hff, 32'h3c);
      wr(`UMAF_OFF_CSA, 32'h01);
      far.send(9'h0f0, 9, 1'b1, 16);
      rd("refilter drops", `UMAF_OFF_CSA, 32'h9c, 32'h00);
   endtask

   // Eight-bit characters: first stop bit is the frame type
   task automatic t_eight;
      wr(`UMAF_OFF_CSB, 32'h18);
      far.send(9'h05a, 8, 1'b0, 16);
      rd("stop zero dropped", `UMAF_OFF_CSA, 32'h9c, 32'h00);
      far.send(9'h05b, 8, 1'b1, 16);
      rd("stop one kept", `UMAF_OFF_CSA, 32'h9c, 32'h80);
      rd("kept data", `UMAF_OFF_DATA, 32'hff, 32'h5b);
   endtask

   // Spike ending before the voted samples, then a real frame
   task automatic t_noise;
      wr(`UMAF_OFF_CSA, 32'h00);
      far.glitch(6);
      rd("spike ignored", `UMAF_OFF_CSA, 32'h80, 32'h00);
      far.send(9'h081, 8, 1'b1, 16);
      rd("after spike", `UMAF_OFF_DATA, 32'hff, 32'h81);
      rd("buffer empty", `UMAF_OFF_CSA, 32'h80, 32'h00);
   endtask

   // Transmitter sends normally with the filter on
   task automatic t_tx;
      wr(`UMAF_OFF_CSA, 32'h01);
      wr(`UMAF_OFF_DATA, 32'ha5);
      far.recv(got, 16);
      chk("tx byte", 32'ha5, {24'h0, got});
   endtask

   // Double speed: eight samples per bit
   task automatic t_dbl;
      wr(`UMAF_OFF_CSA, 32'h02);
      far.send(9'h066, 8, 1'b1, 8);
      rd("double speed", `UMAF_OFF_DATA, 32'hff, 32'h66);
   endtask

   // Incoming rate 3 percent slow and fast against 32 clocks per bit
   task automatic t_range;
      wr(`UMAF_OFF_CSA, 32'h00);
      wr(`UMAF_OFF_BAUD, 32'h01);
      far.send(9'h03c, 8, 1'b1, 33);
      rd("slow rate", `UMAF_OFF_DATA, 32'hff, 32'h3c);
      far.send(9'h0c3, 8, 1'b1, 31);
      rd("fast rate", `UMAF_OFF_DATA, 32'hff, 32'hc3);
   endtask

   // Verdict, used by the main sequence and the watchdog
   task automatic results;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      repeat (6) @(posedge ref_clk);
      arst_n <= 1'b1;
      t_reset;
      t_nine;
      t_eight;
      t_noise;
      t_tx;
      t_dbl;
      t_range;
      results;
   end

   // Watchdog, far beyond the roughly 2400 cycles the tests take
   initial
   begin
      #2000000;
      errors++;
      $display("[FAIL] watchdog expected done seen hang");
      results;
   end
endmodule
`default_nettype wire
